/* File: aswd_map.vh */
// Purpose: Register indices, field positions, reset values and timing counts
// Assumes: Included by every design file of the converter start/window block
// Notes:   Bus address is the register index (Avalon word address)
`ifndef ASWD_MAP_VH
`define ASWD_MAP_VH

// ****************************************
// Register indices
// ****************************************
`define ASWD_IDX_UPPER_LOW   8'hc3
`define ASWD_IDX_UPPER_HIGH  8'hc4
`define ASWD_IDX_LOWER_LOW   8'hc5
`define ASWD_IDX_LOWER_HIGH  8'hc6
`define ASWD_IDX_CONTROL     8'he8
`define ASWD_IDX_RESULT_LOW  8'hd0
`define ASWD_IDX_RESULT_HIGH 8'hd1
`define ASWD_IDX_IRQ_STATUS  8'hd2
`define ASWD_IDX_IRQ_MASK    8'hd3

// ****************************************
// Control register fields
// ****************************************
`define ASWD_CTL_ENABLE      7
`define ASWD_CTL_LOW_POWER   6
`define ASWD_CTL_DONE        5
`define ASWD_CTL_BUSY        4
`define ASWD_CTL_WINDOW      3
`define ASWD_CTL_SEL_HI      2
`define ASWD_CTL_SEL_LO      0

// Interrupt status and mask bits
`define ASWD_IRQ_DONE        0
`define ASWD_IRQ_WINDOW      1

// ****************************************
// Start-select codes
// ****************************************
`define ASWD_SEL_SOFTWARE    3'h0
`define ASWD_SEL_TIMER0      3'h1
`define ASWD_SEL_TIMER2      3'h2
`define ASWD_SEL_TIMER1      3'h3
`define ASWD_SEL_EXTERNAL    3'h4
`define ASWD_SEL_TIMER3      3'h5

// ****************************************
// Reset values
// ****************************************
`define ASWD_RST_UPPER_LOW   8'hff
`define ASWD_RST_UPPER_HIGH  8'hff
`define ASWD_RST_LOWER_LOW   8'h00
`define ASWD_RST_LOWER_HIGH  8'h00
`define ASWD_RST_CONTROL     8'h00
`define ASWD_RST_MASK        8'h00

// ****************************************
// Timing
// ****************************************
`define ASWD_REFCLK_KHZ      25000
`define ASWD_SARCLK_MAX_KHZ  3000
`define ASWD_SAR_DIV         ((`ASWD_REFCLK_KHZ + `ASWD_SARCLK_MAX_KHZ - 1) / `ASWD_SARCLK_MAX_KHZ)
`define ASWD_TRACK_SARCLKS   3
`define ASWD_CONV_SARCLKS    10

`endif

/* File: aswd_window_cmp.v */
// Purpose: Window comparison of a conversion word against two 16-bit limits
// Assumes: Unsigned right-justified result words
// Notes:   Pure combinational; the caller decides when a match counts
`timescale 1ns/1ps
`include "aswd_map.vh"

module aswd_window_cmp #(
  parameter WIDTH = 16
) (
  resultWord,
  upperBound,
  lowerBound,
  windowHit,
  insideMode
);
  input  wire [WIDTH-1:0] resultWord;
  input  wire [WIDTH-1:0] upperBound;
  input  wire [WIDTH-1:0] lowerBound;
  output wire             windowHit;
  output wire             insideMode;

  // ****************************************
  // Inside or outside, chosen by the limits alone
  // ****************************************
  // RQ10 mode from limits
  assign insideMode = (upperBound < lowerBound);

  // RQ14 strictly between limits
  assign windowHit = insideMode
                     ? ((resultWord > upperBound) && (resultWord < lowerBound))
                     : ((resultWord < lowerBound) || (resultWord > upperBound));

endmodule // aswd_window_cmp

/* File: aswd_adc_ctrl.v */
// Purpose: Conversion start selection, tracking sequencing and window detection
// Assumes: Avalon-MM slave, word addressed; timer overflows are one-cycle pulses on ref_clk
// Notes:   The converter core is outside; its result arrives on sampleData at conversion end
//
// Summary of operation
// RQ1 - Normal mode, code 011: each timer 1 overflow starts a conversion.
// RQ2 - Normal mode, code 100: each external start rising edge starts a conversion.
// RQ3 - Normal mode, code 101: each timer 3 overflow starts a conversion.
// RQ4 - Low-power, code 000: busy write of one tracks 3 SAR clocks, then converts.
// RQ5 - Low-power, code 001: timer 0 overflow tracks 3 SAR clocks, then converts.
// RQ6 - Low-power, code 010: timer 2 overflow tracks 3 SAR clocks, then converts.
// RQ7 - Low-power, code 011: timer 1 overflow tracks 3 SAR clocks, then converts.
// RQ8 - Low-power, code 100: track while external start low, convert on its rise.
// RQ9 - Result is compared continuously with the limits; matches notify the system.
// RQ10 - Inside or outside window is selected only by the two limit values.
// RQ11 - Window flag sits in control register; usable as interrupt or polled.
// RQ12 - Each limit is a 16-bit word split into high and low bytes.
// RQ13 - Upper-bound low byte at 0xC3, read-write, resets to all ones.
// RQ14 - Upper below lower: match only strictly between the limits.
// RQ15 - Normal mode codes 000, 001, 010: busy write, timer 0, timer 2 start.
// RQ16 - Software must not program codes 110 or 111.
// RQ17 - Window flag is set by a matching conversion and stays until cleared.
`timescale 1ns/1ps
`include "aswd_map.vh"

module aswd_adc_ctrl #(
  parameter SAR_DIV     = `ASWD_SAR_DIV,
  parameter TRACK_TICKS = `ASWD_TRACK_SARCLKS,
  parameter CONV_TICKS  = `ASWD_CONV_SARCLKS,
  parameter RES_WIDTH   = 10
) (
  ref_clk,
  reset,
  clkEn,
  address,
  read,
  write,
  writedata,
  byteenable,
  readdata,
  waitrequest,
  timer0Overflow,
  timer1Overflow,
  timer2Overflow,
  timer3Overflow,
  externalConvertStart,
  sampleData,
  trackActive,
  convertActive,
  windowMatchLevel,
  irq
);
  input  wire                 ref_clk;
  input  wire                 reset;
  input  wire                 clkEn;
  input  wire [7:0]           address;
  input  wire                 read;
  input  wire                 write;
  input  wire [31:0]          writedata;
  input  wire [3:0]           byteenable;
  output reg  [31:0]          readdata;
  output wire                 waitrequest;
  input  wire                 timer0Overflow;
  input  wire                 timer1Overflow;
  input  wire                 timer2Overflow;
  input  wire                 timer3Overflow;
  input  wire                 externalConvertStart;
  input  wire [RES_WIDTH-1:0] sampleData;
  output wire                 trackActive;
  output wire                 convertActive;
  output wire                 windowMatchLevel;
  output wire                 irq;

  localparam ST_IDLE  = 2'd0;
  localparam ST_TRACK = 2'd1;
  localparam ST_CONV  = 2'd2;

  // Control reset image, so each field takes its own bits of it
  localparam [7:0] CTL_RESET = `ASWD_RST_CONTROL;

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  upperLow_reg;
  reg  [7:0]  upperHigh_reg;
  reg  [7:0]  lowerLow_reg;
  reg  [7:0]  lowerHigh_reg;
  reg         enable_reg;
  reg         lowPowerTrackSelect_reg;
  reg  [2:0]  conversionStartSelect_reg;
  reg         doneFlag_reg;
  reg         windowMatchFlag_reg;
  reg  [7:0]  irqMask_reg;
  reg  [15:0] result_reg;
  reg         ack_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [3:0]  tickCount_reg;
  reg  [3:0]  tickCount_next;
  reg  [7:0]  sarDiv_reg;
  reg         resultFresh_reg;
  reg  [2:0]  extSync_reg;

  wire        sarTick;
  wire        extRise;
  wire        extLow;
  wire        wrEn;
  wire        busyWriteOne;
  wire        startEvent;
  wire        convDone;
  wire        windowHit;
  wire        windowSet;
  wire        doneSet;
  wire [7:0]  irqStatus;
  wire [7:0]  controlByte;

  // Register index decode for the write paths; the read path decodes address in its own case
  function isReg;
    input [7:0] addr;
    input [7:0] idx;
    begin
      isReg = (addr == idx);
    end
  endfunction

  // ****************************************
  // Avalon slave handshake
  // ****************************************
  // One wait state: the access completes on the second edge of the request
  assign waitrequest = (read | write) & ~ack_reg;
  assign wrEn        = write & ack_reg & byteenable[0] & clkEn;

  always @(posedge ref_clk)
  begin
    if (reset)
      ack_reg <= 1'b0;
    else if (clkEn)
      ack_reg <= (read | write) & ~ack_reg;
  end

  // ****************************************
  // External start pin synchroniser
  // ****************************************
  // Stage 0 feeds only stage 1; edges are seen between stages 1 and 2
  always @(posedge ref_clk)
  begin
    if (reset)
      extSync_reg <= 3'h7;
    else if (clkEn)
      extSync_reg <= {extSync_reg[1:0], externalConvertStart};
  end

  assign extRise = extSync_reg[1] & ~extSync_reg[2];
  assign extLow  = ~extSync_reg[1];

  // ****************************************
  // SAR clock divider
  // ****************************************
  // SAR clock stays within its 3 MHz limit by dividing ref_clk
  always @(posedge ref_clk)
  begin
    if (reset)
      sarDiv_reg <= 8'h00;
    else if (clkEn)
    begin
      if (sarDiv_reg == SAR_DIV[7:0] - 8'h01)
        sarDiv_reg <= 8'h00;
      else
        sarDiv_reg <= sarDiv_reg + 8'h01;
    end
  end

  assign sarTick = (sarDiv_reg == SAR_DIV[7:0] - 8'h01);

  // ****************************************
  // Start selection
  // ****************************************
  assign busyWriteOne = wrEn & isReg(address, `ASWD_IDX_CONTROL) & writedata[`ASWD_CTL_BUSY];

  reg selEvent;
  always @*
  begin
    selEvent = 1'b0;
    case (conversionStartSelect_reg)
      // RQ4 RQ15 busy write start
      `ASWD_SEL_SOFTWARE: selEvent = busyWriteOne;
      // RQ5 RQ15 timer 0
      `ASWD_SEL_TIMER0:   selEvent = timer0Overflow;
      // RQ6 RQ15 timer 2
      `ASWD_SEL_TIMER2:   selEvent = timer2Overflow;
      // RQ1 RQ7 timer 1
      `ASWD_SEL_TIMER1:   selEvent = timer1Overflow;
      // RQ2 RQ8 external rising edge
      `ASWD_SEL_EXTERNAL: selEvent = extRise;
      // RQ3 timer 3
      `ASWD_SEL_TIMER3:   selEvent = timer3Overflow;
      // RQ16 reserved codes never start
      default:            selEvent = 1'b0;
    endcase
  end

  assign startEvent = enable_reg & selEvent;

  // ****************************************
  // Track and convert sequencer
  // ****************************************
  always @*
  begin
    state_next     = state_reg;
    tickCount_next = tickCount_reg;
    case (state_reg)
      ST_IDLE:
      begin
        tickCount_next = 4'h0;
        if (startEvent)
        begin
          // RQ2 RQ8 external edge converts at once
          if (lowPowerTrackSelect_reg && conversionStartSelect_reg != `ASWD_SEL_EXTERNAL)
            state_next = ST_TRACK;
          else
            state_next = ST_CONV;
        end
      end
      ST_TRACK:
      begin
        // RQ4 RQ5 RQ6 RQ7 three SAR clocks tracking
        if (sarTick)
        begin
          if (tickCount_reg == TRACK_TICKS[3:0] - 4'h1)
          begin
            tickCount_next = 4'h0;
            state_next     = ST_CONV;
          end
          else
            tickCount_next = tickCount_reg + 4'h1;
        end
      end
      ST_CONV:
      begin
        if (sarTick)
        begin
          if (tickCount_reg == CONV_TICKS[3:0] - 4'h1)
          begin
            tickCount_next = 4'h0;
            state_next     = ST_IDLE;
          end
          else
            tickCount_next = tickCount_reg + 4'h1;
        end
      end
      default:
      begin
        state_next     = ST_IDLE;
        tickCount_next = 4'h0;
      end
    endcase
    // Disabling the converter abandons any conversion in flight
    if (!enable_reg)
    begin
      state_next     = ST_IDLE;
      tickCount_next = 4'h0;
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg     <= ST_IDLE;
      tickCount_reg <= 4'h0;
    end
    else if (clkEn)
    begin
      state_reg     <= state_next;
      tickCount_reg <= tickCount_next;
    end
  end

  assign convDone = (state_reg == ST_CONV) && sarTick && (tickCount_reg == CONV_TICKS[3:0] - 4'h1) && enable_reg;

  // RQ8 track while pin low
  assign trackActive = enable_reg && ((state_reg == ST_TRACK) ||
                       (state_reg == ST_IDLE && (!lowPowerTrackSelect_reg ||
                        (conversionStartSelect_reg == `ASWD_SEL_EXTERNAL && extLow))));
  assign convertActive = (state_reg == ST_CONV);

  // ****************************************
  // Result capture and window detector
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      result_reg      <= 16'h0000;
      resultFresh_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      resultFresh_reg <= convDone;
      if (convDone)
        result_reg <= {{(16-RES_WIDTH){1'b0}}, sampleData};
    end
  end

  // RQ9 RQ12 continuous compare on 16-bit limits
  aswd_window_cmp #(
    .WIDTH (16)
  ) u_window (
    .resultWord (result_reg),
    .upperBound ({upperHigh_reg, upperLow_reg}),
    .lowerBound ({lowerHigh_reg, lowerLow_reg}),
    .windowHit  (windowHit),
    .insideMode ()
  );

  assign windowMatchLevel = windowHit;
  // RQ17 set by matching completed conversion
  assign windowSet = resultFresh_reg & windowHit;
  assign doneSet   = resultFresh_reg;

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      // RQ13 upper low byte resets to ones
      upperLow_reg              <= `ASWD_RST_UPPER_LOW;
      upperHigh_reg             <= `ASWD_RST_UPPER_HIGH;
      lowerLow_reg              <= `ASWD_RST_LOWER_LOW;
      lowerHigh_reg             <= `ASWD_RST_LOWER_HIGH;
      enable_reg                <= CTL_RESET[`ASWD_CTL_ENABLE];
      lowPowerTrackSelect_reg   <= CTL_RESET[`ASWD_CTL_LOW_POWER];
      conversionStartSelect_reg <= CTL_RESET[`ASWD_CTL_SEL_HI:`ASWD_CTL_SEL_LO];
      doneFlag_reg              <= 1'b0;
      windowMatchFlag_reg       <= 1'b0;
      irqMask_reg               <= `ASWD_RST_MASK;
    end
    else if (clkEn)
    begin
      if (wrEn)
      begin
        // RQ12 RQ13 byte-wide limit registers
        if (isReg(address, `ASWD_IDX_UPPER_LOW))
          upperLow_reg <= writedata[7:0];
        if (isReg(address, `ASWD_IDX_UPPER_HIGH))
          upperHigh_reg <= writedata[7:0];
        if (isReg(address, `ASWD_IDX_LOWER_LOW))
          lowerLow_reg <= writedata[7:0];
        if (isReg(address, `ASWD_IDX_LOWER_HIGH))
          lowerHigh_reg <= writedata[7:0];
        if (isReg(address, `ASWD_IDX_IRQ_MASK))
          irqMask_reg <= writedata[7:0];
        if (isReg(address, `ASWD_IDX_CONTROL))
        begin
          enable_reg                <= writedata[`ASWD_CTL_ENABLE];
          lowPowerTrackSelect_reg   <= writedata[`ASWD_CTL_LOW_POWER];
          conversionStartSelect_reg <= writedata[`ASWD_CTL_SEL_HI:`ASWD_CTL_SEL_LO];
        end
      end
      // Flags: control write of zero or status write of one clears; a set wins
      if (doneSet)
        doneFlag_reg <= 1'b1;
      else if (wrEn && ((isReg(address, `ASWD_IDX_CONTROL) && !writedata[`ASWD_CTL_DONE]) ||
               (isReg(address, `ASWD_IDX_IRQ_STATUS) && writedata[`ASWD_IRQ_DONE])))
        doneFlag_reg <= 1'b0;
      // RQ17 RQ11 sticky until software clears
      if (windowSet)
        windowMatchFlag_reg <= 1'b1;
      else if (wrEn && ((isReg(address, `ASWD_IDX_CONTROL) && !writedata[`ASWD_CTL_WINDOW]) ||
               (isReg(address, `ASWD_IDX_IRQ_STATUS) && writedata[`ASWD_IRQ_WINDOW])))
        windowMatchFlag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Register reads and interrupt
  // ****************************************
  assign irqStatus   = {6'h00, windowMatchFlag_reg, doneFlag_reg};
  // RQ11 window flag polled in control
  assign controlByte = {enable_reg, lowPowerTrackSelect_reg, doneFlag_reg,
                        (state_reg != ST_IDLE), windowMatchFlag_reg, conversionStartSelect_reg};

  // RQ11 window flag as interrupt
  assign irq = |(irqStatus & irqMask_reg);

  reg [7:0] readByte;
  always @*
  begin
    readByte = 8'h00;
    case (address)
      `ASWD_IDX_UPPER_LOW:   readByte = upperLow_reg;
      `ASWD_IDX_UPPER_HIGH:  readByte = upperHigh_reg;
      `ASWD_IDX_LOWER_LOW:   readByte = lowerLow_reg;
      `ASWD_IDX_LOWER_HIGH:  readByte = lowerHigh_reg;
      `ASWD_IDX_CONTROL:     readByte = controlByte;
      `ASWD_IDX_RESULT_LOW:  readByte = result_reg[7:0];
      `ASWD_IDX_RESULT_HIGH: readByte = result_reg[15:8];
      `ASWD_IDX_IRQ_STATUS:  readByte = irqStatus;
      `ASWD_IDX_IRQ_MASK:    readByte = irqMask_reg;
      default:               readByte = 8'h00;
    endcase
  end

  // Read data is sampled on the first edge so it stands when waitrequest drops
  always @(posedge ref_clk)
  begin
    if (reset)
      readdata <= 32'h00000000;
    else if (clkEn && read && !ack_reg)
      readdata <= {24'h000000, readByte};
  end

endmodule // aswd_adc_ctrl

/* File: aswd_adc_ctrl_properties.sv */
// Purpose: Port-level checks of the converter start and window block
// Assumes: Start configuration is shadowed from accepted bus writes
// Notes:   Cycle windows allow for the free-running SAR tick phase
`timescale 1ns/1ps
`include "aswd_map.vh"

module aswd_ctrl_props #(
  parameter SAR_DIV     = 2,
  parameter TRACK_TICKS = 3,
  parameter CONV_TICKS  = 10
) (
  input wire        ref_clk,
  input wire        reset,
  input wire        clkEn,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        timer1Overflow,
  input wire        trackActive,
  input wire        convertActive,
  input wire        irq
);
  localparam int CONV_MIN = (CONV_TICKS - 1) * SAR_DIV;
  localparam int CONV_MAX = CONV_TICKS * SAR_DIV;
  localparam int TRK_MIN  = (TRACK_TICKS - 1) * SAR_DIV;
  localparam int TRK_MAX  = TRACK_TICKS * SAR_DIV;
  reg  [7:0] ctlReg;
  reg  [7:0] convCnt;
  reg  [7:0] trkCnt;
  wire       ctlWrite = write && !waitrequest && address == `ASWD_IDX_CONTROL && byteenable[0];

  // ****************************************
  // Shadow of start configuration and phase lengths
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctlReg  <= 8'h00;
      convCnt <= 8'h00;
      trkCnt  <= 8'h00;
    end
    else
    begin
      ctlReg  <= ctlWrite ? writedata[7:0] : ctlReg;
      convCnt <= convertActive ? convCnt + 8'h01 : 8'h00;
      trkCnt  <= trackActive ? trkCnt + 8'h01 : 8'h00;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  wait_state_a: assert property (clkEn && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait state");
  byte_read_a: assert property (readdata[31:8] == 24'h0)
    else $error("read data above the byte lane not zero");
  reset_idle_a: assert property ($fell(reset) |-> !convertActive && !trackActive && !irq)
    else $error("block not idle after reset");
  phase_excl_a: assert property (!(trackActive && convertActive))
    else $error("tracking and converting at once");
  conv_len_a: assert property ($fell(convertActive) |-> convCnt >= CONV_MIN && convCnt <= CONV_MAX)
    else $error("conversion length out of range");
  track_len_a: assert property ($rose(convertActive) && ctlReg[6] && ctlReg[2:0] != 3'h4
    |-> trkCnt >= TRK_MIN && trkCnt <= TRK_MAX)
    else $error("low-power tracking length out of range");
  timer1_start_a: assert property (ctlReg[7:6] == 2'b10 && ctlReg[2:0] == 3'h3 && timer1Overflow && trackActive
    && !convertActive && !write
    |=> convertActive)
    else $error("timer 1 overflow did not start a conversion");
  reserved_a: assert property (ctlReg[2:1] == 2'b11 && !convertActive |=> !convertActive)
    else $error("reserved start code began a conversion");
  busy_start_a: assert property (ctlWrite && writedata[7] && writedata[4] && writedata[2:0] == 3'h0
    && !convertActive && (!ctlReg[6] || !trackActive)
    |=> ($past(writedata[6]) ? trackActive && !convertActive : convertActive))
    else $error("busy write did not start the right phase");

  cover property (ctlReg == 8'h83 && timer1Overflow ##1 convertActive);
  cover property (ctlReg[6] && $rose(convertActive));
  cover property ($rose(irq));
endmodule // aswd_ctrl_props

/* File: aswd_far_side.sv */
// Purpose: Timers, start pin and converter core seen from the block
// Assumes: Timer overflows are one-cycle pulses on the block's clock
// Notes:   Start pin idles high, so the first edge seen is a fall
`timescale 1ns/1ps

module aswd_far_side (
  input  wire       ref_clk,
  output reg        timer0Overflow = 1'b0,
  output reg        timer1Overflow = 1'b0,
  output reg        timer2Overflow = 1'b0,
  output reg        timer3Overflow = 1'b0,
  output reg        externalConvertStart = 1'b1,
  output reg  [9:0] sampleData = 10'h000
);
  task fire(input [2:0] code);
    @(posedge ref_clk);
    timer0Overflow <= (code == 3'h1);
    timer2Overflow <= (code == 3'h2);
    timer1Overflow <= (code == 3'h3);
    timer3Overflow <= (code == 3'h5);
    @(posedge ref_clk);
    {timer0Overflow, timer1Overflow, timer2Overflow, timer3Overflow} <= 4'h0;
  endtask

  task setPin(input v);
    @(posedge ref_clk);
    externalConvertStart <= v;
  endtask

  task setSample(input [9:0] v);
    @(posedge ref_clk);
    sampleData <= v;
  endtask
endmodule // aswd_far_side

/* File: aswd_adc_ctrl_tb.sv */
// Purpose: Self-checking bench for the converter start and window block
// Assumes: SAR divider shortened to 2; bus tasks wait for the slave's answer
// Notes:   Flags are checked at the falling edge, after updates land
`timescale 1ns/1ps
`include "aswd_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module aswd_adc_ctrl_tb;
  reg         ref_clk = 1'b0;
  reg         reset = 1'b1;
  reg  [7:0]  address = 8'h00;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg  [31:0] writedata = 32'h0;
  reg  [3:0]  byteenable = 4'h0;
  wire [31:0] readdata;
  wire [9:0]  sampleData;
  wire        waitrequest, t0, t1, t2, t3, pin, trackActive, convertActive, windowMatchLevel, irq;
  int         error_cnt = 0;
  int         compares = 0;
  int         i;
  reg  [7:0]  q;
  bit         seen;
  reg  [9:0]  smp [3] = '{10'h030, 10'h040, 10'h281};
  reg         hit [3] = '{1'b1, 1'b0, 1'b1};

  always #20 ref_clk = ~ref_clk;

  aswd_adc_ctrl #(.SAR_DIV(2)) dut (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer0Overflow(t0), .timer1Overflow(t1), .timer2Overflow(t2),
    .timer3Overflow(t3), .externalConvertStart(pin), .sampleData(sampleData), .trackActive(trackActive),
    .convertActive(convertActive), .windowMatchLevel(windowMatchLevel), .irq(irq));

  aswd_far_side fs (.ref_clk(ref_clk), .timer0Overflow(t0), .timer1Overflow(t1), .timer2Overflow(t2),
    .timer3Overflow(t3), .externalConvertStart(pin), .sampleData(sampleData));

  task end_of_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Held until waitrequest is sampled low at a rising edge; data taken and request released there
  task bus(input w, input [7:0] a, input [7:0] d, input [3:0] be, output [7:0] rq);
    int n;
    n = 0;
    @(posedge ref_clk);
    {address, writedata, byteenable, read, write} <= {a, 24'h0, d, be, !w, w};
    do begin @(posedge ref_clk); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    rq = readdata[7:0];
    {read, write} <= 2'b00;
  endtask

  task limits(input [15:0] up, input [15:0] lo);
    bus(1, `ASWD_IDX_UPPER_LOW, up[7:0], 4'h1, q);
    bus(1, `ASWD_IDX_UPPER_HIGH, up[15:8], 4'h1, q);
    bus(1, `ASWD_IDX_LOWER_LOW, lo[7:0], 4'h1, q);
    bus(1, `ASWD_IDX_LOWER_HIGH, lo[15:8], 4'h1, q);
  endtask

  task run(input [7:0] ctl, input [9:0] s);
    int n;
    fs.setSample(s);
    bus(1, `ASWD_IDX_CONTROL, ctl, 4'h1, q);
    if (ctl[2:0] == 3'h0) bus(1, `ASWD_IDX_CONTROL, ctl | 8'h10, 4'h1, q);
    else if (ctl[2:0] == 3'h4)
    begin
      fs.setPin(1'b0);
      repeat (4) @(negedge ref_clk);
      `CHK(trackActive, 1'b1)
      fs.setPin(1'b1);
    end
    else fs.fire(ctl[2:0]);
    n = 0;
    while (convertActive !== 1'b1 && n < 60) begin @(negedge ref_clk); n++; end
    seen = (convertActive === 1'b1);
    while (convertActive === 1'b1 && n < 120) begin @(negedge ref_clk); n++; end
    repeat (2) @(negedge ref_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    bus(0, `ASWD_IDX_UPPER_LOW, 8'h00, 4'h1, q); `CHK(q, 8'hff)
    bus(0, `ASWD_IDX_UPPER_HIGH, 8'h00, 4'h1, q); `CHK(q, 8'hff)
    bus(1, `ASWD_IDX_UPPER_LOW, 8'h5a, 4'h1, q);
    bus(1, `ASWD_IDX_UPPER_LOW, 8'h11, 4'h0, q);
    bus(0, `ASWD_IDX_UPPER_LOW, 8'h00, 4'h1, q); `CHK(q, 8'h5a)
    bus(0, 8'h10, 8'h00, 4'h1, q); `CHK(q, 8'h00)
    $display("register test done");
    limits(16'h0040, 16'h0080);
    bus(1, `ASWD_IDX_IRQ_MASK, 8'h02, 4'h1, q);
    for (i = 0; i < 6; i++)
    begin
      run(8'h80 | i[7:0], 10'h050 + i[9:0]); `CHK(seen, 1'b1)
      bus(0, `ASWD_IDX_RESULT_LOW, 8'h00, 4'h1, q); `CHK(q, 8'h50 + i[7:0])
      bus(0, `ASWD_IDX_CONTROL, 8'h00, 4'h1, q); `CHK(q[3], 1'b1)
      `CHK(irq, 1'b1)
      bus(1, `ASWD_IDX_IRQ_STATUS, 8'h03, 4'h1, q);
      @(negedge ref_clk); `CHK(irq, 1'b0)
    end
    $display("normal start test done");
    for (i = 0; i < 6; i++)
    begin
      run(8'hc0 | i[7:0], 10'h080 + i[9:0]); `CHK(seen, 1'b1)
      bus(0, `ASWD_IDX_IRQ_STATUS, 8'h00, 4'h1, q); `CHK(q, 8'h01)
      `CHK(irq, 1'b0)
      bus(1, `ASWD_IDX_IRQ_STATUS, 8'h03, 4'h1, q);
    end
    $display("low-power start test done");
    limits(16'h0080, 16'h0040);
    for (i = 0; i < 3; i++)
    begin
      // Control bit 3 written as one so the sticky window flag is not cleared between runs
      run(8'h8b, smp[i]); `CHK(windowMatchLevel, hit[i])
      bus(0, `ASWD_IDX_CONTROL, 8'h00, 4'h1, q); `CHK(q[3], 1'b1)
      bus(0, `ASWD_IDX_RESULT_HIGH, 8'h00, 4'h1, q); `CHK(q, {6'h0, smp[i][9:8]})
    end
    bus(1, `ASWD_IDX_IRQ_STATUS, 8'h03, 4'h1, q);
    bus(0, `ASWD_IDX_CONTROL, 8'h00, 4'h1, q); `CHK(q[3], 1'b0)
    $display("outside window test done");
    run(8'h96, 10'h000); `CHK(seen, 1'b0)
    fs.fire(3'h3);
    @(negedge ref_clk); `CHK(convertActive, 1'b0)
    $display("reserved code test done");
    end_of_test;
  end
endmodule // aswd_adc_ctrl_tb

bind aswd_adc_ctrl aswd_ctrl_props #(.SAR_DIV(SAR_DIV), .TRACK_TICKS(TRACK_TICKS), .CONV_TICKS(CONV_TICKS))
  props (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .timer1Overflow(timer1Overflow), .trackActive(trackActive), .convertActive(convertActive), .irq(irq));
